// file: bench/tb.sv
// Self-checking bench for the oversampling serial receiver
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import urx_pkg::*;
  localparam int DIV = 2;
  localparam int BITC = 16 * DIV;
  logic          sys_clk = 1'b0;
  logic          reset = 1'b1;
  urx_apb_req_t  apb_req = '0;
  urx_apb_rsp_t  apb_rsp;
  logic          rx_line;
  urx_irq_t      irq;
  int            bad_count = 0;
  int            num_checks = 0;
  int            cyc = 0;
  logic [31:0]   q;

  initial forever #2.5 sys_clk = ~sys_clk;

  urx_receiver DUT (.sys_clk(sys_clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
                    .rx_line(rx_line), .irq(irq));
  urx_line_model #(.BIT_CYC(BITC)) line (.sys_clk(sys_clk), .rx_line(rx_line));

  // ==========================================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Setup then access; waits for pready, release only after it
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask : rdc
  // Polls status until the buffer reports full, then checks the flag set
  task automatic wait_full(input logic [31:0] e);
    q = 32'h0;
    for (int i = 0; i < 200 && q[URX_S1_FULL] !== 1'b1; i++) apb(URX_OFF_STATUS_ONE, 1'b0, 32'h0);
    chk("status_one", e, q & 32'h0000002F);
  endtask : wait_full

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdc(URX_OFF_CONTROL_ONE, 32'h0, "control_one");
    rdc(URX_OFF_CONTROL_TWO, 32'h0, "control_two");
    rdc(URX_OFF_CONTROL_THREE, 32'h0, "control_three");
    rdc(URX_OFF_DIVISOR, 32'h1, "divisor");
    wr(8'h20, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0, "unmapped");
    wr(URX_OFF_DIVISOR, 32'h0);
    rdc(URX_OFF_DIVISOR, 32'h1, "divisor");
    wr(URX_OFF_DIVISOR, DIV);
    wr(URX_OFF_CONTROL_ONE, 32'h20);
    wr(URX_OFF_CONTROL_TWO, 32'h6);
    wr(URX_OFF_CONTROL_THREE, 32'hF);
    $display("test registers done");
    line.send(9'h0A5, 8, 1'b1, -1);
    wait_full(32'h20);
    chk("rx_full_irq", 32'h1, {31'h0, irq.rx_full_irq});
    chk("error_irq", 32'h0, {31'h0, irq.error_irq});
    rdc(URX_OFF_DATA_BUFFER, 32'h1A5, "data_buffer");
    repeat (12 * BITC) @(posedge sys_clk);
    chk("quiet_irq", 32'h1, {31'h0, irq.quiet_irq});
    wr(URX_OFF_CONTROL_TWO, 32'h2);
    $display("test clean character done");
    line.send(9'h0F0, 8, 1'b1, 3);
    wait_full(32'h24);
    chk("error_irq", 32'h1, {31'h0, irq.error_irq});
    rdc(URX_OFF_DATA_BUFFER, 32'h1F0, "data_buffer");
    $display("test noise done");
    line.send(9'h03C, 8, 1'b1, -1);
    line.send(9'h055, 8, 1'b1, -1);
    wait_full(32'h28);
    chk("error_irq", 32'h1, {31'h0, irq.error_irq});
    rdc(URX_OFF_DATA_BUFFER, 32'h03C, "data_buffer");
    $display("test overrun done");
    line.send(9'h000, 8, 1'b0, -1);
    wait_full(32'h22);
    chk("error_irq", 32'h1, {31'h0, irq.error_irq});
    rdc(URX_OFF_DATA_BUFFER, 32'h0, "data_buffer");
    $display("test break done");
    wr(URX_OFF_CONTROL_ONE, 32'h29);
    line.send(9'h001, 9, 1'b1, -1);
    wait_full(32'h21);
    chk("error_irq", 32'h1, {31'h0, irq.error_irq});
    rdc(URX_OFF_DATA_BUFFER, 32'h001, "data_buffer");
    $display("test parity done");
    wr(URX_OFF_CONTROL_ONE, 32'h22);
    wr(URX_OFF_CONTROL_TWO, 32'h3);
    line.send(9'h012, 8, 1'b1, -1);
    repeat (40) @(posedge sys_clk);
    chk("irq", 32'h0, {29'h0, irq});
    rdc(URX_OFF_CONTROL_TWO, 32'h3, "control_two");
    line.send(9'h092, 8, 1'b1, -1);
    wait_full(32'h20);
    rdc(URX_OFF_CONTROL_TWO, 32'h2, "control_two");
    rdc(URX_OFF_DATA_BUFFER, 32'h192, "data_buffer");
    wr(URX_OFF_CONTROL_TWO, 32'h3);
    rdc(URX_OFF_CONTROL_TWO, 32'h3, "control_two");
    $display("test address wake done");
    wr(URX_OFF_CONTROL_ONE, 32'h20);
    wr(URX_OFF_CONTROL_TWO, 32'h1);
    repeat (12 * BITC) @(posedge sys_clk);
    rdc(URX_OFF_CONTROL_TWO, 32'h0, "control_two");
    wr(URX_OFF_CONTROL_THREE, 32'h0);
    chk("error_irq", 32'h0, {31'h0, irq.error_irq});
    $display("test idle wake done");
    give_verdict();
  end
endmodule : tb

// file: bench/urx_line_model.sv
// Remote serial transmitter model driving the receive line
module urx_line_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic sys_clk,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rx_line = 1'b1;
  // ==========================================================================
  // One frame, LSB first; gl picks a bit to corrupt briefly near its centre
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int gl);
    logic v;
    for (int b = 0; b < nb + 2; b++) begin
      for (int c = 0; c < BIT_CYC; c++) begin
        @(posedge sys_clk);
        v = (b == 0) ? 1'b0 : (b > nb) ? stop : d[b-1];
        rx_line <= (b == gl && c >= 16 && c < 18) ? ~v : v;
      end
    end
    @(posedge sys_clk);
    rx_line <= 1'b1;
  endtask : send
endmodule : urx_line_model

// file: bench/urx_rx_monitor.sv
// Port checker for the oversampling serial receiver, bound to its top module
module urx_rx_monitor
  import urx_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire urx_pkg::urx_apb_req_t apb_req,
  input wire urx_pkg::urx_apb_rsp_t apb_rsp,
  input wire logic                  rx_line,
  input wire urx_pkg::urx_irq_t     irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Helper logic
  logic acc;
  logic wr;
  logic rd;
  logic c1_clean_reg;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr  = acc & apb_req.pwrite;
  assign rd  = acc & ~apb_req.pwrite;
  // Remembers that control_one still holds its reset value
  always_ff @(posedge sys_clk) begin
    if (reset) c1_clean_reg <= 1'b1;
    else if (wr && apb_req.paddr == URX_OFF_CONTROL_ONE) c1_clean_reg <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Properties
  property p_ready_high;
    apb_req.psel |-> apb_rsp.pready;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("pready low during a transfer");
  property p_no_slverr;
    acc |-> !apb_rsp.pslverr;
  endproperty
  a_no_slverr: assert property (p_no_slverr) else $error("pslverr raised");
  property p_standby_mutes;
    wr && apb_req.paddr == URX_OFF_CONTROL_TWO && apb_req.pwdata[0] |=> (irq == 3'b000)[*3];
  endproperty
  a_standby_mutes: assert property (p_standby_mutes) else $error("irq seen in standby");
  property p_full_gate;
    wr && apb_req.paddr == URX_OFF_CONTROL_TWO && !apb_req.pwdata[1] |=> !irq.rx_full_irq;
  endproperty
  a_full_gate: assert property (p_full_gate) else $error("rx_full_irq while disabled");
  property p_quiet_gate;
    wr && apb_req.paddr == URX_OFF_CONTROL_TWO && !apb_req.pwdata[2] |=> !irq.quiet_irq;
  endproperty
  a_quiet_gate: assert property (p_quiet_gate) else $error("quiet_irq while disabled");
  property p_err_gate;
    wr && apb_req.paddr == URX_OFF_CONTROL_THREE && apb_req.pwdata[3:0] == 4'h0 |=> !irq.error_irq;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error_irq while disabled");
  property p_unmapped;
    rd && apb_req.paddr > URX_OFF_DIVISOR |-> apb_rsp.prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_divisor;
    rd && apb_req.paddr == URX_OFF_DIVISOR |-> apb_rsp.prdata[15:0] != 16'h0;
  endproperty
  a_divisor: assert property (p_divisor) else $error("divisor reads zero");
  property p_c1_reset;
    rd && apb_req.paddr == URX_OFF_CONTROL_ONE && c1_clean_reg |-> apb_rsp.prdata[1:0] == 2'b00;
  endproperty
  a_c1_reset: assert property (p_c1_reset) else $error("length or wake select not cleared");
endmodule : urx_rx_monitor

bind urx_receiver urx_rx_monitor u_mon (
  .sys_clk (sys_clk),
  .reset   (reset),
  .apb_req (apb_req),
  .apb_rsp (apb_rsp),
  .rx_line (rx_line),
  .irq     (irq)
);

// file: logic/urx_pkg.sv
// Package for the oversampling serial receiver: register map, fields, states
package urx_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] URX_OFF_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] URX_OFF_CONTROL_TWO   = 8'h04;
  localparam logic [7:0] URX_OFF_CONTROL_THREE = 8'h08;
  localparam logic [7:0] URX_OFF_STATUS_ONE    = 8'h0C;
  localparam logic [7:0] URX_OFF_DATA_BUFFER   = 8'h10;
  localparam logic [7:0] URX_OFF_DIVISOR       = 8'h14;

  // ==========================================================================
  // Field positions
  // control_one
  localparam int URX_C1_LONG_CHAR   = 0;
  localparam int URX_C1_WAKE_ADDR   = 1;
  localparam int URX_C1_IDLE_ORIGIN = 2;
  localparam int URX_C1_PARITY_EN   = 3;
  localparam int URX_C1_PARITY_ODD  = 4;
  localparam int URX_C1_RX_EN       = 5;
  // control_two
  localparam int URX_C2_STANDBY     = 0;
  localparam int URX_C2_FULL_IE     = 1;
  localparam int URX_C2_QUIET_IE    = 2;
  // control_three
  localparam int URX_C3_OVERRUN_IE  = 0;
  localparam int URX_C3_NOISE_IE    = 1;
  localparam int URX_C3_FRAMING_IE  = 2;
  localparam int URX_C3_PARITY_IE   = 3;
  // status_one
  localparam int URX_S1_PARITY      = 0;
  localparam int URX_S1_FRAMING     = 1;
  localparam int URX_S1_NOISE       = 2;
  localparam int URX_S1_OVERRUN     = 3;
  localparam int URX_S1_QUIET       = 4;
  localparam int URX_S1_FULL        = 5;
  localparam int URX_S1_ACTIVE      = 6;

  // ==========================================================================
  // Reset values and timing
  localparam logic [5:0]  URX_CONTROL_ONE_RST = 6'h00;
  localparam logic [2:0]  URX_CONTROL_TWO_RST = 3'h0;
  localparam logic [3:0]  URX_CONTROL_THR_RST = 4'h0;
  localparam logic [15:0] URX_DIVISOR_RST     = 16'h0001;
  localparam int          URX_OVERSAMPLE      = 16;
  localparam logic [3:0]  URX_TICK_LAST       = 4'hF;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    URX_HUNT  = 3'b001,
    URX_START = 3'b010,
    URX_BITS  = 3'b100
  } urx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } urx_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } urx_apb_rsp_t;

  typedef struct packed {
    logic rx_full_irq;
    logic quiet_irq;
    logic error_irq;
  } urx_irq_t;

endpackage : urx_pkg

// file: logic/urx_receiver.sv
// Oversampling serial receiver with start verification, wakeup and APB registers
module urx_receiver
  import urx_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire urx_pkg::urx_apb_req_t apb_req,
  output      urx_pkg::urx_apb_rsp_t apb_rsp,
  input  wire logic              rx_line,
  output      urx_pkg::urx_irq_t irq
);
  import urx_pkg::*;

  // ==========================================================================

  typedef struct packed {
    logic [1:0]  sync;
    logic [15:0] div_cnt;
    logic [15:0] divisor;
    logic [5:0]  ctl1;
    logic [2:0]  ctl2;
    logic [3:0]  ctl3;
    logic        f_full, f_quiet, f_over, f_noise, f_frame, f_par;
    logic [8:0]  data_buf;
    logic        full_read;
    urx_state_t  state;
    logic [3:0]  tick;
    logic [2:0]  hist;
    logic [2:0]  vote;
    logic [3:0]  bit_idx;
    logic [9:0]  shift;
    logic        prev_bit;
    logic        c_noise;
    logic [3:0]  ones_cnt;
    logic        idle_armed;
    logic [31:0] prdata;
  } urx_regs_t;

  urx_regs_t r_reg, r_next;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  function automatic logic split3(input logic [2:0] s);
    split3 = (s != 3'b000) && (s != 3'b111);
  endfunction : split3

  logic        ost;
  logic        line;
  logic        long_char, par_en;
  logic [3:0]  last_idx;
  logic [3:0]  idle_len;
  logic        apb_wr, apb_rd;
  logic [31:0] rd_val;
  logic        bit_val;

  assign line      = r_reg.sync[1];
  assign long_char = r_reg.ctl1[URX_C1_LONG_CHAR];
  assign par_en    = r_reg.ctl1[URX_C1_PARITY_EN];
  // Index of stop bit: 1 start + 8 or 9 data
  assign last_idx  = long_char ? 4'hA : 4'h9;
  assign idle_len  = long_char ? 4'hB : 4'hA;
  assign ost       = (r_reg.div_cnt == 16'h0000);
  assign apb_wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign apb_rd    = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (apb_req.paddr)
      URX_OFF_CONTROL_ONE:   rd_val[5:0] = r_reg.ctl1;
      URX_OFF_CONTROL_TWO:   rd_val[2:0] = r_reg.ctl2;
      URX_OFF_CONTROL_THREE: rd_val[3:0] = r_reg.ctl3;
      URX_OFF_STATUS_ONE: begin
        rd_val[URX_S1_PARITY]  = r_reg.f_par;
        rd_val[URX_S1_FRAMING] = r_reg.f_frame;
        rd_val[URX_S1_NOISE]   = r_reg.f_noise;
        rd_val[URX_S1_OVERRUN] = r_reg.f_over;
        rd_val[URX_S1_QUIET]   = r_reg.f_quiet;
        rd_val[URX_S1_FULL]    = r_reg.f_full;
        rd_val[URX_S1_ACTIVE]  = (r_reg.state != URX_HUNT);
      end
      URX_OFF_DATA_BUFFER:   rd_val[8:0] = r_reg.data_buf;
      URX_OFF_DIVISOR:       rd_val[15:0] = r_reg.divisor;
      default:               rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic       ev_full, ev_quiet, ev_over, ev_noise, ev_frame, ev_par;
    logic       stop_ok, parity_bad, addr_mark, standby;
    logic [8:0] dat;
    ev_full  = 1'b0;
    ev_quiet = 1'b0;
    ev_over  = 1'b0;
    ev_noise = 1'b0;
    ev_frame = 1'b0;
    ev_par   = 1'b0;
    stop_ok  = 1'b0;
    parity_bad = 1'b0;
    addr_mark  = 1'b0;
    dat        = 9'h000;
    standby    = r_reg.ctl2[URX_C2_STANDBY];
    bit_val    = maj3(r_reg.vote);
    r_next = r_reg;
    r_next.sync   = {r_reg.sync[0], rx_line};
    r_next.prdata = rd_val;
    r_next.div_cnt = ost ? (r_reg.divisor - 16'h0001) : (r_reg.div_cnt - 16'h0001);

    // ========================================================================
    // Bit recovery, advanced once per oversample tick
    if (ost && r_reg.ctl1[URX_C1_RX_EN]) begin
      r_next.hist = {r_reg.hist[1:0], line};
      r_next.tick = r_reg.tick + 4'h1;
      if (r_reg.tick == 4'h7) r_next.vote[0] = line;
      if (r_reg.tick == 4'h8) r_next.vote[1] = line;
      if (r_reg.tick == 4'h9) r_next.vote[2] = line;
      case (r_reg.state)
        URX_HUNT: begin
          if (r_reg.hist == 3'b111 && !line) begin
            r_next.state   = URX_START;
            r_next.tick    = 4'h1;
            r_next.c_noise = 1'b0;
          end
        end
        URX_START: begin
          if (r_reg.tick == 4'h3) r_next.vote[0] = line;
          if (r_reg.tick == 4'h5) r_next.vote[1] = line;
          if (r_reg.tick == 4'h7) begin
            // Ticks 3,5,7 vote; samples at ticks 7-9 only flag noise, checked at tick 10
            if (maj3({line, r_reg.vote[1:0]})) begin
              r_next.state = URX_HUNT;
              r_next.tick  = 4'h0;
              r_next.hist  = 3'b000;
            end else if (split3({line, r_reg.vote[1:0]})) begin
              r_next.c_noise = 1'b1;
            end
          end
          if (r_reg.tick == 4'hA && r_reg.vote != 3'b000)
            r_next.c_noise = 1'b1;
          if (r_reg.tick == URX_TICK_LAST) begin
            r_next.state    = URX_BITS;
            r_next.tick     = 4'h0;
            r_next.bit_idx  = 4'h1;
            r_next.prev_bit = 1'b0;
          end
        end
        URX_BITS: begin
          // Falling edge after a bit that voted 1 realigns the count
          if (r_reg.prev_bit && r_reg.hist[0] && !line && r_reg.tick > 4'hA
              && r_reg.bit_idx != last_idx) begin
            // Index already advanced at the vote; only the count realigns
            r_next.tick = 4'h1;
          end
          if (r_reg.tick == 4'hA) begin
            if (split3(r_reg.vote)) r_next.c_noise = 1'b1;
            r_next.prev_bit = bit_val;
            r_next.shift = {bit_val, r_reg.shift[9:1]};
            if (r_reg.bit_idx == last_idx) begin
              r_next.state = URX_HUNT;
              r_next.tick  = 4'h0;
              r_next.hist  = {2'b00, bit_val};
              stop_ok = bit_val;
              dat = long_char ? r_reg.shift[9:1] : {r_reg.shift[9], r_reg.shift[9:2]};
              parity_bad = par_en && ((^dat[7:0] ^ (long_char & dat[8])) != r_reg.ctl1[URX_C1_PARITY_ODD]);
              addr_mark = long_char ? dat[8] : dat[7];
              // Standby drops all but the waking address mark
              if (!standby || (r_reg.ctl1[URX_C1_WAKE_ADDR] && addr_mark)) begin
                if (standby) r_next.ctl2[URX_C2_STANDBY] = 1'b0;
                if (r_reg.f_full && !r_reg.full_read) begin
                  ev_over = 1'b1;
                end else begin
                  r_next.data_buf = dat;
                  ev_full  = 1'b1;
                  ev_frame = !stop_ok;
                  ev_noise = r_reg.c_noise | split3(r_reg.vote);
                  ev_par   = parity_bad;
                end
              end
            end else begin
              r_next.bit_idx = r_reg.bit_idx + 4'h1;
            end
          end else if (r_reg.tick == URX_TICK_LAST) begin
            r_next.tick = 4'h0;
          end
        end
        default: r_next.state = URX_HUNT;
      endcase

      // ======================================================================
      // Idle detection: ones counted from start or stop bit
      if (line && (r_reg.state == URX_HUNT || !r_reg.ctl1[URX_C1_IDLE_ORIGIN])) begin
        if (r_reg.tick == 4'h0 || r_reg.state == URX_HUNT) begin
          if (r_reg.ones_cnt != 4'hF) r_next.ones_cnt = r_reg.ones_cnt + 4'h1;
        end
      end else if (!line) begin
        r_next.ones_cnt   = 4'h0;
        r_next.idle_armed = 1'b1;
      end
      // Counting is per bit time: one count per 16 ticks
      if (r_reg.state == URX_HUNT && r_reg.tick != 4'h0) r_next.ones_cnt = r_reg.ones_cnt;
      if (r_reg.state == URX_HUNT) r_next.tick = (r_next.state == URX_HUNT) ? r_reg.tick + 4'h1 : r_next.tick;
      if (r_reg.ones_cnt >= idle_len && (r_reg.idle_armed || standby)) begin
        r_next.idle_armed = 1'b0;
        if (standby) begin
          if (!r_reg.ctl1[URX_C1_WAKE_ADDR])
            r_next.ctl2[URX_C2_STANDBY] = 1'b0;
        end else begin
          ev_quiet = 1'b1;
        end
      end
    end

    // ========================================================================
    // APB writes; flags clear by status read with full set, then buffer read
    if (apb_rd && apb_req.paddr == URX_OFF_STATUS_ONE && r_reg.f_full)
      r_next.full_read = 1'b1;
    if (apb_wr) begin
      case (apb_req.paddr)
        URX_OFF_CONTROL_ONE:   r_next.ctl1 = apb_req.pwdata[5:0];
        URX_OFF_CONTROL_TWO:   r_next.ctl2 = apb_req.pwdata[2:0];
        URX_OFF_CONTROL_THREE: r_next.ctl3 = apb_req.pwdata[3:0];
        URX_OFF_DIVISOR:       r_next.divisor = (apb_req.pwdata[15:0] == 16'h0000) ? 16'h0001
                                                : apb_req.pwdata[15:0];
        default: ;
      endcase
    end
    if (apb_rd && apb_req.paddr == URX_OFF_DATA_BUFFER && r_reg.full_read) begin
      r_next.f_full    = 1'b0;
      r_next.f_over    = 1'b0;
      r_next.f_noise   = 1'b0;
      r_next.f_frame   = 1'b0;
      r_next.f_par     = 1'b0;
      r_next.f_quiet   = 1'b0;
      r_next.full_read = 1'b0;
    end
    // Set wins over a same-cycle clear
    if (ev_full) r_next.f_full = 1'b1;
    if (ev_quiet) r_next.f_quiet = 1'b1;
    if (ev_over) r_next.f_over = 1'b1;
    if (ev_noise) r_next.f_noise = 1'b1;
    if (ev_frame) r_next.f_frame = 1'b1;
    if (ev_par) r_next.f_par = 1'b1;
    if (ev_full) r_next.full_read = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.sync     <= 2'b11;
      r_reg.divisor  <= URX_DIVISOR_RST;
      r_reg.ctl1     <= URX_CONTROL_ONE_RST;
      r_reg.ctl2     <= URX_CONTROL_TWO_RST;
      r_reg.ctl3     <= URX_CONTROL_THR_RST;
      r_reg.state    <= URX_HUNT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata  = rd_val;

  logic awake;
  assign awake = ~r_reg.ctl2[URX_C2_STANDBY];
  assign irq.rx_full_irq = awake & r_reg.f_full & r_reg.ctl2[URX_C2_FULL_IE];
  assign irq.quiet_irq   = awake & r_reg.f_quiet & r_reg.ctl2[URX_C2_QUIET_IE];
  assign irq.error_irq   = awake & ((r_reg.f_over  & r_reg.ctl3[URX_C3_OVERRUN_IE])
                                  | (r_reg.f_noise & r_reg.ctl3[URX_C3_NOISE_IE])
                                  | (r_reg.f_frame & r_reg.ctl3[URX_C3_FRAMING_IE])
                                  | (r_reg.f_par   & r_reg.ctl3[URX_C3_PARITY_IE]));

endmodule : urx_receiver
